// >>> audio_clock_sync_pins.v
`timescale 1ns/1ps
`include "audio_pins_consts.vh"

// clock, frame sync and flag pin logic of the serial audio port
// pad inputs cross a two-flop synchroniser, so pad-derived
// edges and flags lag the pin by three core cycles
module audio_clock_sync_pins
#(
	parameter [7:0] HF_DIV  = `HF_DIV_DEFAULT,
	parameter [7:0] BIT_DIV = `BIT_DIV_DEFAULT
)
(
	input  wire        clk,
	input  wire        rst_n,
	// pads
	input  wire [5:0]  pin_in,
	output wire [5:0]  pin_out,
	output wire [5:0]  pin_oe,
	// per-pin function and gpio control
	input  wire [5:0]  audio_func_sel,
	input  wire [11:0] gpio_mode,
	input  wire [5:0]  gpio_out,
	output wire [5:0]  gpio_in,
	// mode and direction bits
	input  wire        sync_mode_select,
	input  wire        network_mode,
	input  wire        tx_ext_buffer_enable_select,
	input  wire        rx_frame_sync_direction,
	input  wire        tx_frame_sync_direction,
	input  wire        rx_bit_clock_direction,
	input  wire        tx_bit_clock_direction,
	input  wire        rx_high_freq_clock_direction,
	input  wire        tx_high_freq_clock_direction,
	input  wire        rx_clock_source_select,
	input  wire        tx_clock_source_select,
	// flag bits and drives from the serial sections
	input  wire        output_flag_zero,
	input  wire        output_flag_one,
	input  wire        rx_frame_sync_drive,
	input  wire        tx_frame_sync_drive,
	input  wire        tx_ext_buffer_enable,
	input  wire        slot_strobe,
	// to the serial sections
	output reg         rx_clock_tick,
	output reg         tx_clock_tick,
	output reg         rx_bit_edge,
	output reg         tx_bit_edge,
	output reg         rx_frame_sync,
	output reg         tx_frame_sync,
	output reg         input_flag_zero,
	output reg         input_flag_one
);

	// pad state and per-pad drive
	wire [5:0] pin_level;     // synchronised pad levels
	reg  [5:0] pin_prev;      // previous synchronised levels
	wire [5:0] pin_rise;      // rising edges seen on pads
	reg  [5:0] func_out;      // function drive value per pad
	reg  [5:0] func_oe;       // function drive enable per pad

	// dividers, generated clocks and held flags
	reg  [7:0] hf_cnt;        // core clock divider for hf outputs
	reg        hf_clk;        // divided high-frequency clock
	reg  [7:0] tx_bit_cnt;    // transmit bit clock divider
	reg        tx_bit_clk;    // generated transmit bit clock
	reg  [7:0] rx_bit_cnt;    // receive bit clock divider
	reg        rx_bit_clk;    // generated receive bit clock
	reg        tx_bit_gen;    // pulse on generated tx rising edge
	reg        rx_bit_gen;    // pulse on generated rx rising edge
	reg        flag_one_out;  // output flag one held at the pad
	reg        flag_zero_out; // output flag zero held at the pad
	reg        tx_fs_prev;    // previous active tx frame sync

	// source choice, frame syncs and bit edges
	wire       rx_hf_ext;     // receiver clocked from hf pad
	wire       tx_hf_ext;     // transmitter clocked from hf pad
	wire       rx_src_tick;   // receiver source clock tick
	wire       tx_src_tick;   // transmitter source clock tick
	wire       tx_fs_level;   // active transmit frame sync
	wire       rx_fs_level;   // active receive frame sync
	wire       rx_fs_flag;    // rx frame sync pad is flag one
	wire       flag_strobe;   // flag update instant
	wire       next_tx_bit;   // next transmit bit edge
	wire       next_rx_bit;   // next receive bit edge

	// pad index of the cell array
	genvar i;

	// one pad cell per audio pin
	generate
		for (i = 0; i < 6; i = i + 1)
		begin : g_pad
			audio_pin_cell u_cell
			(
				.clk       (clk),
				.rst_n     (rst_n),
				.pin_in    (pin_in[i]),
				.func_sel  (audio_func_sel[i]),
				.gpio_mode (gpio_mode[2*i+1:2*i]),
				.gpio_out  (gpio_out[i]),
				.func_out  (func_out[i]),
				.func_oe   (func_oe[i]),
				.pin_out   (pin_out[i]),
				.pin_oe    (pin_oe[i]),
				.pin_level (pin_level[i]),
				.gpio_in   (gpio_in[i])
			);
		end
	endgenerate

	// rising edge of each pad, one cycle wide
	assign pin_rise = pin_level & ~pin_prev;

	// edge history of the synchronised pads; it resets to the
	// pull-down level so no false edge follows reset
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pin_prev <= 6'h00;
		else
			pin_prev <= pin_level;
	end

	// hf pads as inputs replace the core clock as source
	// only a function pad set as input may clock a section
	assign rx_hf_ext = rx_clock_source_select
		& audio_func_sel[`PIN_RX_HF]
		& ~rx_high_freq_clock_direction;
	assign tx_hf_ext = tx_clock_source_select
		& audio_func_sel[`PIN_TX_HF]
		& ~tx_high_freq_clock_direction;
	assign rx_src_tick = rx_hf_ext ? pin_rise[`PIN_RX_HF] : 1'b1;
	assign tx_src_tick = tx_hf_ext ? pin_rise[`PIN_TX_HF] : 1'b1;

	// divided core clock for hf pads driven as outputs
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hf_cnt <= `CNT_RESET;
			hf_clk <= `PIN_RESET;
		end
		else if (hf_cnt >= HF_DIV - 8'h01)
		begin
			// half period reached: flip the clock
			hf_cnt <= `CNT_RESET;
			hf_clk <= ~hf_clk;
		end
		else
			// still counting toward the half period
			hf_cnt <= hf_cnt + 8'h01;
	end

	// transmit bit clock generated from its source ticks
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_bit_cnt <= `CNT_RESET;
			tx_bit_clk <= `PIN_RESET;
			tx_bit_gen <= `PIN_RESET;
		end
		else if (tx_src_tick && tx_bit_cnt >= BIT_DIV - 8'h01)
		begin
			// half bit period: toggle, mark the rising edge
			tx_bit_cnt <= `CNT_RESET;
			tx_bit_clk <= ~tx_bit_clk;
			tx_bit_gen <= ~tx_bit_clk;
		end
		else
		begin
			// count only ticks of the chosen source
			if (tx_src_tick)
				tx_bit_cnt <= tx_bit_cnt + 8'h01;
			tx_bit_gen <= 1'b0;
		end
	end

	// receive bit clock generated from its source ticks
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_bit_cnt <= `CNT_RESET;
			rx_bit_clk <= `PIN_RESET;
			rx_bit_gen <= `PIN_RESET;
		end
		else if (rx_src_tick && rx_bit_cnt >= BIT_DIV - 8'h01)
		begin
			// half bit period: toggle, mark the rising edge
			rx_bit_cnt <= `CNT_RESET;
			rx_bit_clk <= ~rx_bit_clk;
			rx_bit_gen <= ~rx_bit_clk;
		end
		else
		begin
			// count only ticks of the chosen source
			if (rx_src_tick)
				rx_bit_cnt <= rx_bit_cnt + 8'h01;
			rx_bit_gen <= 1'b0;
		end
	end

	// bit edges seen by each section
	// a bit clock pad set as input is edge detected after sync
	assign next_tx_bit = tx_bit_clock_direction ? tx_bit_gen
		: pin_rise[`PIN_TX_BIT];
	assign next_rx_bit = sync_mode_select ? next_tx_bit
		: (rx_bit_clock_direction ? rx_bit_gen
		: pin_rise[`PIN_RX_BIT]);

	// frame syncs: tx pad in sync mode, own pads otherwise
	// async receive: own drive when output, pad level when input
	assign tx_fs_level = tx_frame_sync_direction ? tx_frame_sync_drive
		: pin_level[`PIN_TX_FS];
	assign rx_fs_level = sync_mode_select ? tx_fs_level
		: (rx_frame_sync_direction ? rx_frame_sync_drive
		: pin_level[`PIN_RX_FS]);

	// flag updates follow frame start, or each slot in network mode
	assign flag_strobe = network_mode ? slot_strobe
		: (tx_fs_level & ~tx_fs_prev);
	assign rx_fs_flag = sync_mode_select
		& ~tx_ext_buffer_enable_select;

	// pad drive values for the audio function
	always @*
	begin
		func_out = 6'h00;
		func_oe  = 6'h00;
		// hf pads: divided clock out when set as output
		// both hf pads share the one divided clock
		func_out[`PIN_RX_HF] = hf_clk;
		func_oe[`PIN_RX_HF]  = rx_high_freq_clock_direction;
		func_out[`PIN_TX_HF] = hf_clk;
		func_oe[`PIN_TX_HF]  = tx_high_freq_clock_direction;
		// tx frame sync pad follows its direction bit
		func_out[`PIN_TX_FS] = tx_frame_sync_drive;
		func_oe[`PIN_TX_FS]  = tx_frame_sync_direction;
		// tx bit clock pad
		func_out[`PIN_TX_BIT] = tx_bit_clk;
		func_oe[`PIN_TX_BIT]  = tx_bit_clock_direction;
		// rx bit clock pad: flag zero in sync mode
		if (sync_mode_select)
		begin
			func_out[`PIN_RX_BIT] = flag_zero_out;
			func_oe[`PIN_RX_BIT]  = rx_bit_clock_direction;
		end
		else
		begin
			// async mode: generated receive bit clock
			func_out[`PIN_RX_BIT] = rx_bit_clk;
			func_oe[`PIN_RX_BIT]  = rx_bit_clock_direction;
		end
		// rx frame sync pad: frame sync, flag one or buffer enable
		if (!sync_mode_select)
		begin
			func_out[`PIN_RX_FS] = rx_frame_sync_drive;
			func_oe[`PIN_RX_FS]  = rx_frame_sync_direction;
		end
		else if (rx_fs_flag)
		begin
			func_out[`PIN_RX_FS] = flag_one_out;
			func_oe[`PIN_RX_FS]  = rx_frame_sync_direction;
		end
		else if (rx_frame_sync_direction)
		begin
			func_out[`PIN_RX_FS] = tx_ext_buffer_enable;
			func_oe[`PIN_RX_FS]  = 1'b1;
		end
		else
		begin
			// buffer select without output direction: pad left as input
			func_out[`PIN_RX_FS] = 1'b0;
			func_oe[`PIN_RX_FS]  = 1'b0;
		end
	end

	// output flags latched at the update instant
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flag_one_out  <= `PIN_RESET;
			flag_zero_out <= `PIN_RESET;
			tx_fs_prev    <= `PIN_RESET;
		end
		else
		begin
			// remember frame sync for its rising edge
			tx_fs_prev <= tx_fs_level;
			// new flag values only at the update instant
			if (flag_strobe)
			begin
				flag_one_out  <= output_flag_one;
				flag_zero_out <= output_flag_zero;
			end
		end
	end

	// input flags sampled at the update instant
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			input_flag_one  <= `PIN_RESET;
			input_flag_zero <= `PIN_RESET;
		end
		else if (flag_strobe)
		begin
			// only a flag pad set as input is sampled
			if (rx_fs_flag && !rx_frame_sync_direction)
				input_flag_one <= pin_level[`PIN_RX_FS];
			// flag zero pad is read only in sync mode as input
			if (sync_mode_select && !rx_bit_clock_direction)
				input_flag_zero <= pin_level[`PIN_RX_BIT];
		end
	end

	// registered clock and frame outputs to the serial sections
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_clock_tick <= `PIN_RESET;
			tx_clock_tick <= `PIN_RESET;
			rx_bit_edge   <= `PIN_RESET;
			tx_bit_edge   <= `PIN_RESET;
			rx_frame_sync <= `PIN_RESET;
			tx_frame_sync <= `PIN_RESET;
		end
		else
		begin
			// one register stage keeps outputs glitch free
			rx_clock_tick <= rx_src_tick;
			tx_clock_tick <= tx_src_tick;
			rx_bit_edge   <= next_rx_bit;
			tx_bit_edge   <= next_tx_bit;
			rx_frame_sync <= rx_fs_level;
			tx_frame_sync <= tx_fs_level;
		end
	end

endmodule // audio_clock_sync_pins

// >>> audio_clock_sync_pins_bench.sv
`timescale 1ns/1ps
// directed bench of the clock and frame sync pad logic
module audio_clock_sync_pins_bench;
	reg         clk, rst_n, sync, net, buf_sel, rx_fs_dir, tx_fs_dir;
	reg         rx_hf_dir, tx_hf_dir, rx_src, tx_src, flag1, fs_drv, buf_en;
	reg         slot, hf_run, flag_lvl, fs_lvl;
	reg         rx_bit_dir, tx_bit_dir, flag0, rx_fs_drv;
	reg  [5:0]  func_sel, gpio_out, n2, n5;
	reg  [11:0] gpio_mode;
	wire [5:0]  pin_in, pin_out, pin_oe, gpio_in;
	wire        rx_tick, tx_tick, rx_fs, tx_fs, in_flag1;
	wire        rx_edge, tx_edge, in_flag0;
	int         fail_count, num_checks, cycles;
	audio_clock_sync_pins i_audio_clock_sync_pins (.clk(clk), .rst_n(rst_n),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.audio_func_sel(func_sel), .gpio_mode(gpio_mode), .gpio_out(gpio_out),
		.gpio_in(gpio_in), .sync_mode_select(sync), .network_mode(net),
		.tx_ext_buffer_enable_select(buf_sel),
		.rx_frame_sync_direction(rx_fs_dir), .tx_frame_sync_direction(tx_fs_dir),
		.rx_bit_clock_direction(rx_bit_dir),
		.tx_bit_clock_direction(tx_bit_dir),
		.rx_high_freq_clock_direction(rx_hf_dir),
		.tx_high_freq_clock_direction(tx_hf_dir),
		.rx_clock_source_select(rx_src), .tx_clock_source_select(tx_src),
		.output_flag_zero(flag0), .output_flag_one(flag1),
		.rx_frame_sync_drive(rx_fs_drv), .tx_frame_sync_drive(fs_drv),
		.tx_ext_buffer_enable(buf_en), .slot_strobe(slot),
		.rx_clock_tick(rx_tick), .tx_clock_tick(tx_tick),
		.rx_bit_edge(rx_edge), .tx_bit_edge(tx_edge),
		.rx_frame_sync(rx_fs), .tx_frame_sync(tx_fs),
		.input_flag_zero(in_flag0), .input_flag_one(in_flag1));
	codec_model i_codec_model (.pin_out(pin_out), .pin_oe(pin_oe),
		.hf_run(hf_run), .flag_lvl(flag_lvl), .fs_lvl(fs_lvl), .pin_in(pin_in));
	always #12.5 clk = ~clk;
	// hang guard: the tests need well under 500 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fail_count++;
			tally_and_finish;
		end
	end
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [5:0] got, input logic [5:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// one internal frame sync, then time for the flag to settle
	task pulse_fs;
		fs_drv = 1'b1;
		cyc(2);
		fs_drv = 1'b0;
		cyc(6);
	endtask
	task t_gpio;
		chk(pin_oe, 6'h00);
		chk(gpio_in, 6'h00);
		gpio_out = 6'h2A;
		gpio_mode = 12'hAAA;
		cyc(2);
		chk(pin_oe, 6'h3F);
		chk(pin_out, 6'h2A);
		{flag_lvl, fs_lvl} = 2'h3;
		gpio_mode = 12'h555;
		cyc(5);
		chk(gpio_in, 6'h13);
		gpio_mode = 12'hFFF;
		cyc(5);
		chk(gpio_in | pin_oe, 6'h00);
		{flag_lvl, fs_lvl} = 2'h0;
		$display("gpio test done");
	endtask
	task t_hf;
		func_sel = 6'h24;
		{rx_hf_dir, tx_hf_dir} = 2'h3;
		cyc(4);
		chk(pin_oe, 6'h24);
		{n2, n5} = 12'h000;
		repeat (8)
		begin
			{n2[5], n5[5]} = {pin_out[2], pin_out[5]};
			cyc(1);
			n2[4:0] += (pin_out[2] != n2[5]);
			n5[4:0] += (pin_out[5] != n5[5]);
		end
		chk({n2[4:0], n5[4:0] == 5'h08}, 6'h11);
		// release both hf pads first so no driven edge is counted
		{rx_hf_dir, tx_hf_dir} = 2'h0;
		cyc(4);
		{rx_src, tx_src, hf_run} = 3'h7;
		{n2, n5} = 12'h000;
		repeat (80)
		begin
			cyc(1);
			n2 += rx_tick;
			n5 += tx_tick;
		end
		chk({n2 >= 9 && n2 <= 11, n5 >= 9 && n5 <= 11}, 6'h03);
		{rx_src, tx_src, hf_run} = 3'h0;
		cyc(4);
		chk({rx_tick, tx_tick}, 6'h03);
		$display("hf clock test done");
	endtask
	task t_fs;
		func_sel = 6'h12;
		{tx_fs_dir, fs_drv, rx_fs_dir, rx_fs_drv} = 4'hF;
		cyc(3);
		chk(pin_oe & pin_out, 6'h12);
		chk({5'h00, rx_fs}, 6'h01);
		{tx_fs_dir, fs_drv, rx_fs_dir, fs_lvl} = 4'h1;
		cyc(5);
		chk({tx_fs, rx_fs}, 6'h02);
		flag_lvl = 1'b1;
		cyc(5);
		chk({5'h00, rx_fs}, 6'h01);
		flag_lvl = 1'b0;
		sync = 1'b1;
		cyc(5);
		chk({5'h00, rx_fs}, 6'h01);
		fs_lvl = 1'b0;
		cyc(5);
		chk({5'h00, rx_fs}, 6'h00);
		$display("frame sync test done");
	endtask
	task t_flags;
		{tx_fs_dir, rx_fs_dir, flag1} = 3'h7;
		pulse_fs;
		chk(pin_oe & pin_out & 6'h02, 6'h02);
		flag1 = 1'b0;
		cyc(6);
		chk(pin_out & 6'h02, 6'h02);
		pulse_fs;
		chk(pin_out & 6'h02, 6'h00);
		{rx_fs_dir, flag_lvl} = 2'h1;
		// let the released pad settle through the synchroniser
		cyc(4);
		pulse_fs;
		chk({pin_oe[1], in_flag1}, 6'h01);
		flag_lvl = 1'b0;
		cyc(6);
		chk({5'h00, in_flag1}, 6'h01);
		{net, slot} = 2'h3;
		cyc(1);
		slot = 1'b0;
		cyc(6);
		chk({5'h00, in_flag1}, 6'h00);
		net = 1'b0;
		$display("flag test done");
	endtask
	task t_buf;
		{buf_sel, rx_fs_dir, buf_en} = 3'h7;
		cyc(3);
		chk(pin_oe & pin_out & 6'h02, 6'h02);
		buf_en = 1'b0;
		cyc(3);
		chk(pin_out & 6'h02, 6'h00);
		$display("buffer enable test done");
	endtask
	// sync mode: rx bit pad is flag zero, bit edges from tx clock
	task t_bit;
		func_sel = 6'h1B;
		{tx_bit_dir, rx_bit_dir, flag0} = 3'h7;
		pulse_fs;
		chk(pin_oe & pin_out & 6'h01, 6'h01);
		{n2, n5} = 12'h000;
		repeat (80)
		begin
			cyc(1);
			n2 += rx_edge;
			n5 += tx_edge;
		end
		// four-cycle half period: one rising edge every eight cycles
		chk({n2[4:0], n5 == 6'h0A}, 6'h15);
		{rx_bit_dir, flag_lvl} = 2'h1;
		cyc(4);
		pulse_fs;
		chk({pin_oe[0], in_flag0}, 6'h01);
		flag_lvl = 1'b0;
		$display("bit clock test done");
	endtask
	initial
	begin
		{clk, rst_n, sync, net, buf_sel, rx_fs_dir, tx_fs_dir, rx_hf_dir} = '0;
		{tx_hf_dir, rx_src, tx_src, flag1, fs_drv, buf_en, slot, hf_run} = '0;
		{flag_lvl, fs_lvl, func_sel, gpio_out, gpio_mode} = '0;
		{rx_bit_dir, tx_bit_dir, flag0, rx_fs_drv} = '0;
		{fail_count, num_checks, cycles} = '0;
		cyc(20);
		rst_n = 1'b1;
		cyc(2);
		t_gpio;
		t_hf;
		t_fs;
		t_flags;
		t_buf;
		t_bit;
		tally_and_finish;
	end
endmodule // audio_clock_sync_pins_bench

// >>> audio_clock_sync_pins_properties.sv
`timescale 1ns/1ps
// watches pad, bit edge and tick ports of the pin block
module audio_pins_checker
(
	input wire        clk,
	input wire        rst_n,
	input wire [5:0]  pin_in,
	input wire [5:0]  pin_out,
	input wire [5:0]  pin_oe,
	input wire [5:0]  audio_func_sel,
	input wire [11:0] gpio_mode,
	input wire [5:0]  gpio_out,
	input wire        sync_mode_select,
	input wire        tx_ext_buffer_enable_select,
	input wire        rx_frame_sync_direction,
	input wire        tx_frame_sync_direction,
	input wire        tx_high_freq_clock_direction,
	input wire        tx_clock_source_select,
	input wire        tx_frame_sync_drive,
	input wire        tx_ext_buffer_enable,
	input wire        tx_clock_tick,
	input wire        rx_bit_edge,
	input wire        tx_bit_edge
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// pads stay released on the first edge after reset
	property p_reset_idle;
		$rose(rst_n) |-> pin_oe == 6'h00;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("pad driven at reset exit");
	property p_gpio_drive;
		$past(rst_n) && !audio_func_sel[3] && gpio_mode[7:6] == 2'h2
		|=> pin_oe[3] && pin_out[3] == $past(gpio_out[3]);
	endproperty
	a_gpio_drive: assert property (p_gpio_drive) else $error("gpio drive wrong");
	property p_gpio_off;
		!audio_func_sel[0] && (gpio_mode[1:0] == 2'h0 || gpio_mode[1:0] == 2'h3)
		|=> !pin_oe[0];
	endproperty
	a_gpio_off: assert property (p_gpio_off) else $error("off pad driven");
	property p_tx_fs_dir;
		$past(rst_n) && audio_func_sel[4] |=> pin_oe[4] == $past(tx_frame_sync_direction);
	endproperty
	a_tx_fs_dir: assert property (p_tx_fs_dir) else $error("tx fs direction");
	property p_tx_fs_val;
		$past(rst_n) && audio_func_sel[4] && tx_frame_sync_direction
		|=> pin_out[4] == $past(tx_frame_sync_drive);
	endproperty
	a_tx_fs_val: assert property (p_tx_fs_val) else $error("tx fs value");
	property p_flag_dir;
		$past(rst_n) && audio_func_sel[1] && sync_mode_select
		&& !tx_ext_buffer_enable_select
		|=> pin_oe[1] == $past(rx_frame_sync_direction);
	endproperty
	a_flag_dir: assert property (p_flag_dir) else $error("flag direction");
	property p_buf_en;
		$past(rst_n) && audio_func_sel[1] && sync_mode_select
		&& tx_ext_buffer_enable_select && rx_frame_sync_direction
		|=> pin_oe[1] && pin_out[1] == $past(tx_ext_buffer_enable);
	endproperty
	a_buf_en: assert property (p_buf_en) else $error("buffer enable pad");
	property p_hf_toggle;
		(audio_func_sel[5] && tx_high_freq_clock_direction)[*4] ##0 $past(rst_n, 3)
		|-> pin_oe[5] && pin_out[5] != $past(pin_out[5]);
	endproperty
	a_hf_toggle: assert property (p_hf_toggle) else $error("hf clock stuck");
	property p_hf_tick;
		audio_func_sel[5] && !tx_high_freq_clock_direction && tx_clock_source_select
		&& $rose(pin_in[5]) |-> ##[2:4] tx_clock_tick;
	endproperty
	a_hf_tick: assert property (p_hf_tick) else $error("no hf tick");
	property p_core_tick;
		$past(rst_n) && !tx_clock_source_select |=> tx_clock_tick;
	endproperty
	a_core_tick: assert property (p_core_tick) else $error("core tick gap");
	property p_bit_sync;
		$past(sync_mode_select) |-> rx_bit_edge == tx_bit_edge;
	endproperty
	a_bit_sync: assert property (p_bit_sync) else $error("bit edges differ");
	c_gpio: cover property (p_gpio_drive);
	c_buf: cover property (audio_func_sel[1] && tx_ext_buffer_enable_select);
	c_tick: cover property ($rose(pin_in[5]) && tx_clock_source_select);
endmodule // audio_pins_checker

bind audio_clock_sync_pins audio_pins_checker i_audio_pins_checker (.clk(clk),
	.rst_n(rst_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
	.audio_func_sel(audio_func_sel), .gpio_mode(gpio_mode), .gpio_out(gpio_out),
	.sync_mode_select(sync_mode_select),
	.tx_ext_buffer_enable_select(tx_ext_buffer_enable_select),
	.rx_frame_sync_direction(rx_frame_sync_direction),
	.tx_frame_sync_direction(tx_frame_sync_direction),
	.tx_high_freq_clock_direction(tx_high_freq_clock_direction),
	.tx_clock_source_select(tx_clock_source_select),
	.tx_frame_sync_drive(tx_frame_sync_drive),
	.tx_ext_buffer_enable(tx_ext_buffer_enable), .tx_clock_tick(tx_clock_tick),
	.rx_bit_edge(rx_bit_edge), .tx_bit_edge(tx_bit_edge));

// >>> audio_pin_cell.v
`timescale 1ns/1ps
`include "audio_pins_consts.vh"

// one pad: synchroniser, gpio path and function mux
module audio_pin_cell
(
	input  wire       clk,
	input  wire       rst_n,
	input  wire       pin_in,
	input  wire       func_sel,
	input  wire [1:0] gpio_mode,
	input  wire       gpio_out,
	input  wire       func_out,
	input  wire       func_oe,
	output reg        pin_out,
	output reg        pin_oe,
	output reg        pin_level,
	output reg        gpio_in
);

	reg meta; // first synchroniser stage, read only by pin_level

	// two-stage synchroniser on the pad input
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta      <= `PIN_RESET;
			pin_level <= `PIN_RESET;
		end
		else
		begin
			meta      <= pin_in;
			pin_level <= meta;
		end
	end

	// pad drive: audio function or gpio, disconnected at reset
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_out <= `PIN_RESET;
			pin_oe  <= `PIN_RESET;
			gpio_in <= `PIN_RESET;
		end
		else if (func_sel)
		begin
			// audio port function owns the pad
			pin_out <= func_out;
			pin_oe  <= func_oe;
			gpio_in <= `PIN_RESET;
		end
		else
		begin
			// gpio: only output mode drives, only input mode reads
			pin_oe  <= (gpio_mode == `GPIO_OUT);
			pin_out <= (gpio_mode == `GPIO_OUT) & gpio_out;
			gpio_in <= (gpio_mode == `GPIO_IN) & pin_level;
		end
	end

endmodule // audio_pin_cell

// >>> audio_pins_consts.vh
// Function
// - receive hf pin input clocks receiver
// - receive hf pin output drives hf clock
// - transmit hf pin input clocks transmitter
// - transmit hf pin output drives hf clock
// - gpio pins: input, output or disconnected
// - reset leaves all pins gpio disconnected
// - async mode: rx frame sync serves receivers
// - sync mode, buffer select clear: flag one
// - sync, buffer select, direction: buffer enable
// - flag direction from rx frame sync direction
// - output flag one drives pin value
// - flag output updates per frame or slot
// - input flag one sampled per frame/slot
// - sync mode: tx frame sync for both
// - async mode: tx frame sync transmitters only
// - tx frame sync direction from its bit
// - sync mode: rx bit clock is flag zero
// - tx bit clock serves both in sync
`ifndef AUDIO_PINS_CONSTS_VH
`define AUDIO_PINS_CONSTS_VH

// pin positions in the six-bit pin vectors
`define PIN_RX_BIT 0
`define PIN_RX_FS  1
`define PIN_RX_HF  2
`define PIN_TX_BIT 3
`define PIN_TX_FS  4
`define PIN_TX_HF  5

// gpio mode codes, two bits per pin
`define GPIO_OFF   2'h0
`define GPIO_IN    2'h1
`define GPIO_OUT   2'h2

// reset values
`define PIN_RESET  1'h0
`define CNT_RESET  8'h00

// default divider counts in core cycles or source ticks
`define HF_DIV_DEFAULT  8'h01
`define BIT_DIV_DEFAULT 8'h04

`endif

// >>> codec_model.sv
`timescale 1ns/1ps
// external codec: drives the pads it owns, pull-downs elsewhere
module codec_model
(
	input  wire [5:0] pin_out,
	input  wire [5:0] pin_oe,
	input  wire       hf_run,
	input  wire       flag_lvl,
	input  wire       fs_lvl,
	output wire [5:0] pin_in
);
	reg        hf_clk; // 200 ns link clock, still while idle
	wire [5:0] ext;    // codec drive on hf, frame sync and both flag pads
	// offset start keeps link edges off the core clock edges
	initial
	begin
		hf_clk = 1'b0;
		#37;
		forever #100 hf_clk = hf_run ? ~hf_clk : 1'b0;
	end
	assign ext = {hf_clk, fs_lvl, 1'b0, hf_clk, flag_lvl, flag_lvl};
	// device drive wins, pads it releases take the codec drive
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // codec_model
